// ===== hdl/mqscp_defines.vh
`ifndef MQSCP_DEFINES_VH
`define MQSCP_DEFINES_VH

// address layout
`define MQSCP_QUAD_HI          19
`define MQSCP_QUAD_LO          18
`define MQSCP_LINE_16          16
`define MQSCP_LINE_18          18
`define MQSCP_LINE_19          19
`define MQSCP_SEG_SHIFT        12
`define MQSCP_CODE_ZONE_NIB    4'he

// bank control field positions, one 8-bit field per quadrant
`define MQSCP_BANK_W           8
`define MQSCP_BANK_CS_HI       1
`define MQSCP_BANK_CS_LO       0
`define MQSCP_BANK_PAIR_EN     2
`define MQSCP_BANK_PAIR_SEL    3
`define MQSCP_BANK_INV16       4
`define MQSCP_BANK_INV18       5
`define MQSCP_BANK_INV19       6

// reset values
`define MQSCP_PAGE_RST         8'h00
`define MQSCP_PC_RST           16'h0000

// transfer kinds
`define MQSCP_XK_JP            3'h0
`define MQSCP_XK_CALL          3'h1
`define MQSCP_XK_RET           3'h2
`define MQSCP_XK_LJP           3'h3
`define MQSCP_XK_LCALL         3'h4
`define MQSCP_XK_LRET          3'h5

// transfer durations in clocks; call plus return: long 32, short 20
`define MQSCP_CLK_JP           5'h07
`define MQSCP_CLK_CALL         5'h0c
`define MQSCP_CLK_RET          5'h08
`define MQSCP_CLK_LJP          5'h0a
`define MQSCP_CLK_LCALL        5'h13
`define MQSCP_CLK_LRET         5'h0d

// memory cycle states
`define MQSCP_ST_IDLE          2'h0
`define MQSCP_ST_T1            2'h1
`define MQSCP_ST_T2            2'h2

`endif

// ===== hdl/mqscp_xfer.v
`timescale 1ns/100ps
`default_nettype none
`include "mqscp_defines.vh"

module mqscp_xfer (
   // clock and reset
   input  wire        clk,
   input  wire        nrst,
   // transfer request
   input  wire        xfer_start,
   input  wire [2:0]  xfer_kind,
   input  wire [15:0] xfer_target_pc,
   input  wire [7:0]  xfer_target_page,
   // state
   output wire        xfer_ready,
   output reg         xfer_done_q,
   output reg  [15:0] pc_q,
   output reg  [7:0]  page_q
);

   reg  [4:0]  count_q;
   reg  [2:0]  kind_q;
   reg  [15:0] tpc_q;
   reg  [7:0]  tpage_q;

   // clocks each kind of transfer occupies
   function [4:0] mqscp_clocks;
      input [2:0] kind;
      begin
         case (kind)
            `MQSCP_XK_JP:    mqscp_clocks = `MQSCP_CLK_JP;
            `MQSCP_XK_CALL:  mqscp_clocks = `MQSCP_CLK_CALL;
            `MQSCP_XK_RET:   mqscp_clocks = `MQSCP_CLK_RET;
            `MQSCP_XK_LJP:   mqscp_clocks = `MQSCP_CLK_LJP;
            `MQSCP_XK_LCALL: mqscp_clocks = `MQSCP_CLK_LCALL;
            `MQSCP_XK_LRET:  mqscp_clocks = `MQSCP_CLK_LRET;
            default:         mqscp_clocks = `MQSCP_CLK_JP;
         endcase
      end
   endfunction

   // only long kinds carry a new page
   function mqscp_is_long;
      input [2:0] kind;
      begin
         mqscp_is_long = (kind == `MQSCP_XK_LJP) || (kind == `MQSCP_XK_LCALL) ||
                         (kind == `MQSCP_XK_LRET);
      end
   endfunction

   assign xfer_ready = (count_q == 5'h00);

   // count down the transfer, then commit pc and, for long kinds, the page
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         count_q     <= 5'h00;
         kind_q      <= `MQSCP_XK_JP;
         tpc_q       <= `MQSCP_PC_RST;
         tpage_q     <= `MQSCP_PAGE_RST;
         pc_q        <= `MQSCP_PC_RST;
         page_q      <= `MQSCP_PAGE_RST;
         xfer_done_q <= 1'b0;
      end else begin
         xfer_done_q <= 1'b0;
         if (xfer_ready && xfer_start) begin
            count_q <= mqscp_clocks(xfer_kind);
            kind_q  <= xfer_kind;
            tpc_q   <= xfer_target_pc;
            tpage_q <= xfer_target_page;
         end else if (count_q != 5'h00) begin
            count_q <= count_q - 5'h01;
            if (count_q == 5'h01) begin
               pc_q        <= tpc_q;
               xfer_done_q <= 1'b1;
               if (mqscp_is_long(kind_q)) begin
                  page_q <= tpage_q;
               end                                    // short kinds keep the page
            end
         end
      end
   end

endmodule
`default_nettype wire

// ===== hdl/mqscp_mem_iface.v
// Functional notes
// - address lines 16, 18 and 19 may be altered per configuration before driving out.
// - all other physical address lines pass straight through unchanged.
// - three active-low chip selects, two output enables, two write enables.
// - physical space split into four 256K quadrants, strobes chosen per quadrant.
// - quadrant bank setting picks one chip select or none (code 3), and optionally one strobe pair.
// - an 8-bit code page register places the code window in physical memory.
// - the code window always spans 8K of logical space.
// - code window placement moves in 4K steps.
// - long jump, call and return update both pc and code page register.
// - long call plus return take 32 clocks; short pair takes 20 clocks.
// - ordinary 16-bit transfers reach all segments without touching the page.
// - non-root zones add the 8-bit segment to the upper logical nibble.
// - lowest zone maps directly; boundary register holds two 4-bit zone starts.
`timescale 1ns/100ps
`default_nettype none
`include "mqscp_defines.vh"

module mqscp_mem_iface #(
   parameter NUM_QUADS = 4
) (
   // clock and reset
   input  wire                            clk,
   input  wire                            nrst,
   // processor memory request
   input  wire                            mem_req,
   input  wire                            mem_write,
   input  wire [15:0]                     logical_addr,
   output wire                            mem_ready,
   output reg                             mem_done_q,
   // mapping configuration
   input  wire [7:0]                      zone_boundary_register,
   input  wire [7:0]                      data_segment,
   input  wire [7:0]                      stack_segment,
   input  wire [NUM_QUADS*`MQSCP_BANK_W-1:0] bank_control,
   // program transfers
   input  wire                            xfer_start,
   input  wire [2:0]                      xfer_kind,
   input  wire [15:0]                     xfer_target_pc,
   input  wire [7:0]                      xfer_target_page,
   output wire                            xfer_ready,
   output wire                            xfer_done,
   output wire [15:0]                     program_counter,
   output wire [7:0]                      code_page_register,
   // external memory bus
   output reg  [19:0]                     mem_addr_q,
   output reg                             chip_select_0_n,
   output reg                             chip_select_1_n,
   output reg                             chip_select_2_n,
   output reg                             output_enable_0_n,
   output reg                             output_enable_1_n,
   output reg                             write_enable_0_n,
   output reg                             write_enable_1_n
);

   reg  [1:0]                  state_q;
   reg                         write_q;
   reg  [1:0]                  cs_sel_q;
   reg                         pair_en_q;
   reg                         pair_sel_q;
   reg  [7:0]                  seg_d;
   reg  [19:0]                 phys_d;
   reg  [19:0]                 out_addr_d;
   reg  [`MQSCP_BANK_W-1:0]    bank_d;
   wire [3:0]                  nib;
   wire [3:0]                  data_start;
   wire [3:0]                  stack_start;
   wire [1:0]                  quad;
   wire                        accept;

   // transfer sequencer owns pc and the code page
   mqscp_xfer u_xfer (
      .clk              (clk),
      .nrst             (nrst),
      .xfer_start       (xfer_start),
      .xfer_kind        (xfer_kind),
      .xfer_target_pc   (xfer_target_pc),
      .xfer_target_page (xfer_target_page),
      .xfer_ready       (xfer_ready),
      .xfer_done_q      (xfer_done),
      .pc_q             (program_counter),
      .page_q           (code_page_register)
   );

   // one-cold chip select vector for a select code; code 3 leaves every chip idle
   function [2:0] mqscp_cs_n;
      input [1:0] sel;
      begin
         case (sel)
            2'h0:    mqscp_cs_n = 3'h6;
            2'h1:    mqscp_cs_n = 3'h5;
            2'h2:    mqscp_cs_n = 3'h3;
            default: mqscp_cs_n = 3'h7;
         endcase
      end
   endfunction

   // zone boundaries: low nibble starts the data zone, high nibble the stack zone
   assign nib         = logical_addr[15:12];
   assign data_start  = zone_boundary_register[3:0];
   assign stack_start = zone_boundary_register[7:4];

   // pick the segment for the addressed zone; code window is fixed at the top 8K
   always @* begin
      if (nib >= `MQSCP_CODE_ZONE_NIB) begin
         seg_d = code_page_register;
      end else if (nib >= stack_start) begin
         seg_d = stack_segment;
      end else if (nib >= data_start) begin
         seg_d = data_segment;
      end else begin
         seg_d = 8'h00;
      end
   end

   // segment weighs 4K per step, so the window slides by half its size
   always @* begin
      phys_d = {4'h0, logical_addr} + {seg_d, 12'h000};
   end

   // quadrant is decided on the unaltered top bits
   assign quad = phys_d[`MQSCP_QUAD_HI:`MQSCP_QUAD_LO];

   // fetch the bank field of the addressed quadrant
   always @* begin
      bank_d = bank_control[quad*`MQSCP_BANK_W +: `MQSCP_BANK_W];
   end

   // optional inversion of three lines; the rest pass untouched
   always @* begin
      out_addr_d = phys_d;
      out_addr_d[`MQSCP_LINE_16] = phys_d[`MQSCP_LINE_16] ^ bank_d[`MQSCP_BANK_INV16];
      out_addr_d[`MQSCP_LINE_18] = phys_d[`MQSCP_LINE_18] ^ bank_d[`MQSCP_BANK_INV18];
      out_addr_d[`MQSCP_LINE_19] = phys_d[`MQSCP_LINE_19] ^ bank_d[`MQSCP_BANK_INV19];
   end

   // a new cycle is taken only between cycles, so strobes never overlap
   assign mem_ready = (state_q == `MQSCP_ST_IDLE);
   assign accept    = mem_ready && mem_req;

   // two-clock memory cycle: T1 drives select and read enable, T2 adds write enable
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_q    <= `MQSCP_ST_IDLE;
         write_q    <= 1'b0;
         cs_sel_q   <= 2'h3;
         pair_en_q  <= 1'b0;
         pair_sel_q <= 1'b0;
         mem_addr_q <= 20'h00000;
         mem_done_q <= 1'b0;
      end else begin
         mem_done_q <= 1'b0;
         case (state_q)
            `MQSCP_ST_IDLE: begin
               if (accept) begin
                  state_q    <= `MQSCP_ST_T1;
                  write_q    <= mem_write;
                  cs_sel_q   <= bank_d[`MQSCP_BANK_CS_HI:`MQSCP_BANK_CS_LO];
                  pair_en_q  <= bank_d[`MQSCP_BANK_PAIR_EN];
                  pair_sel_q <= bank_d[`MQSCP_BANK_PAIR_SEL];
                  mem_addr_q <= out_addr_d;
               end
            end
            `MQSCP_ST_T1: begin
               state_q <= `MQSCP_ST_T2;
            end
            `MQSCP_ST_T2: begin
               state_q    <= `MQSCP_ST_IDLE;
               mem_done_q <= 1'b1;
            end
            default: begin
               state_q <= `MQSCP_ST_IDLE;
            end
         endcase
      end
   end

   // strobes are registered so they change glitch-free on clock edges
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         chip_select_0_n   <= 1'b1;
         chip_select_1_n   <= 1'b1;
         chip_select_2_n   <= 1'b1;
         output_enable_0_n <= 1'b1;
         output_enable_1_n <= 1'b1;
         write_enable_0_n  <= 1'b1;
         write_enable_1_n  <= 1'b1;
      end else begin
         case (state_q)
            `MQSCP_ST_IDLE: begin
               // select code 3 leaves every chip idle
               {chip_select_2_n, chip_select_1_n, chip_select_0_n} <=
                  accept ? mqscp_cs_n(bank_d[`MQSCP_BANK_CS_HI:`MQSCP_BANK_CS_LO]) : 3'h7;
               output_enable_0_n <= ~(accept && !mem_write && bank_d[`MQSCP_BANK_PAIR_EN] &&
                                      !bank_d[`MQSCP_BANK_PAIR_SEL]);
               output_enable_1_n <= ~(accept && !mem_write && bank_d[`MQSCP_BANK_PAIR_EN] &&
                                      bank_d[`MQSCP_BANK_PAIR_SEL]);
               write_enable_0_n  <= 1'b1;
               write_enable_1_n  <= 1'b1;
            end
            `MQSCP_ST_T1: begin
               // write enable waits a clock so address and select are settled first
               write_enable_0_n <= ~(write_q && pair_en_q && !pair_sel_q);
               write_enable_1_n <= ~(write_q && pair_en_q && pair_sel_q);
               // select and read enable are held from the captured setting, not the live one
               {chip_select_2_n, chip_select_1_n, chip_select_0_n} <= mqscp_cs_n(cs_sel_q);
               output_enable_0_n <= ~(!write_q && pair_en_q && !pair_sel_q);
               output_enable_1_n <= ~(!write_q && pair_en_q && pair_sel_q);
            end
            default: begin
               chip_select_0_n   <= 1'b1;
               chip_select_1_n   <= 1'b1;
               chip_select_2_n   <= 1'b1;
               output_enable_0_n <= 1'b1;
               output_enable_1_n <= 1'b1;
               write_enable_0_n  <= 1'b1;
               write_enable_1_n  <= 1'b1;
            end
         endcase
      end
   end

endmodule
`default_nettype wire

// ===== verif/mqscp_checker.sv
`timescale 1ns/100ps
`default_nettype none
`include "mqscp_defines.vh"
module mqscp_checker #(
   parameter NUM_QUADS = 4
) (
   // clock, reset and memory request
   input wire logic        clk, nrst, mem_req, mem_write, mem_ready, mem_done_q,
   input wire logic [15:0] logical_addr, xfer_target_pc, program_counter,
   // mapping configuration
   input wire logic [7:0]  zone_boundary_register, data_segment, stack_segment,
   input wire logic [NUM_QUADS*`MQSCP_BANK_W-1:0] bank_control,
   // transfers
   input wire logic        xfer_start, xfer_ready, xfer_done,
   input wire logic [2:0]  xfer_kind,
   input wire logic [7:0]  xfer_target_page, code_page_register,
   // memory bus
   input wire logic [19:0] mem_addr_q,
   input wire logic        chip_select_0_n, chip_select_1_n, chip_select_2_n,
   input wire logic        output_enable_0_n, output_enable_1_n, write_enable_0_n, write_enable_1_n
);
   // mapping seen at the taking edge; quadrant picked before any inversion
   wire        take = mem_ready && mem_req;
   wire        xtake = xfer_ready && xfer_start;
   wire [3:0]  nib = logical_addr[15:12];
   wire [7:0]  seg = (nib >= `MQSCP_CODE_ZONE_NIB) ? code_page_register :
                     (nib >= zone_boundary_register[7:4]) ? stack_segment :
                     (nib >= zone_boundary_register[3:0]) ? data_segment : 8'h00;
   wire [19:0] phys = {4'h0, logical_addr} + {seg, 12'h000};
   wire [NUM_QUADS*`MQSCP_BANK_W-1:0] sh = bank_control >> {phys[19:18], 3'b000};
   wire [7:0]  fld = sh[7:0];
   wire [16:0] pass_bits = {phys[17], phys[15:0]};
   wire [2:0]  inv_bits = {phys[19] ^ fld[6], phys[18] ^ fld[5], phys[16] ^ fld[4]};
   wire [1:0]  pair_n = fld[2] ? (fld[3] ? 2'b01 : 2'b10) : 2'b11;
   wire [2:0]  cs_vec = {chip_select_2_n, chip_select_1_n, chip_select_0_n};
   wire [1:0]  oe_vec = {output_enable_1_n, output_enable_0_n};
   wire [1:0]  we_vec = {write_enable_1_n, write_enable_0_n};
   wire [4:0]  xlen = (xfer_kind == `MQSCP_XK_JP) ? 5'd7 : (xfer_kind == `MQSCP_XK_CALL) ? 5'd12 :
                      (xfer_kind == `MQSCP_XK_RET) ? 5'd8 : (xfer_kind == `MQSCP_XK_LJP) ? 5'd10 :
                      (xfer_kind == `MQSCP_XK_LCALL) ? 5'd19 : 5'd13;
   reg [2:0]  cs_exp_q;
   reg [1:0]  oe_exp_q, we_exp_q;
   reg [4:0]  xcnt_q, xn_q;
   reg        xlong_q;
   reg [15:0] xpc_q;
   reg [7:0]  xpage_q;
   // capture what each request should produce; counter saturates so it never wraps
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cs_exp_q <= 3'h7; oe_exp_q <= 2'h3; we_exp_q <= 2'h3; xcnt_q <= 5'h1f;
         xn_q <= 5'h00; xlong_q <= 1'b0; xpc_q <= 16'h0000; xpage_q <= 8'h00;
      end else begin
         if (take) begin
            cs_exp_q <= (fld[1:0] == 2'h3) ? 3'h7 : ~(3'h1 << fld[1:0]);
            oe_exp_q <= mem_write ? 2'h3 : pair_n;
            we_exp_q <= mem_write ? pair_n : 2'h3;
         end
         if (xtake) begin
            xcnt_q <= 5'h00; xn_q <= xlen; xlong_q <= (xfer_kind >= `MQSCP_XK_LJP);
            xpc_q <= xfer_target_pc; xpage_q <= xfer_target_page;
         end else if (xcnt_q != 5'h1f) begin
            xcnt_q <= xcnt_q + 5'h01;
         end
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   a_addr_pass: assert property (take |=> {mem_addr_q[17], mem_addr_q[15:0]} == $past(pass_bits))
      else $error("address pass-through bits differ");
   a_addr_invert: assert property (take |=> {mem_addr_q[19:18], mem_addr_q[16]} == $past(inv_bits))
      else $error("altered address lines differ");
   a_strobe_select: assert property (take |=> (cs_vec == cs_exp_q && oe_vec == oe_exp_q) [*2] ##1
      (cs_vec == 3'h7 && oe_vec == 2'h3)) else $error("chip select or output enable wrong");
   a_write_strobe: assert property (take |=> we_vec == 2'h3 ##1 we_vec == we_exp_q ##1 we_vec == 2'h3)
      else $error("write enable wrong");
   a_done_pulse: assert property (take |=> !mem_done_q [*2] ##1 mem_done_q ##1 !mem_done_q)
      else $error("access done pulse misplaced");
   a_busy_span: assert property (take |=> !mem_ready [*2] ##1 mem_ready)
      else $error("access busy span wrong");
   a_idle_quiet: assert property (mem_ready |-> cs_vec == 3'h7 && oe_vec == 2'h3 && we_vec == 2'h3)
      else $error("strobe active while idle");
   a_xfer_busy: assert property (xtake |=> !xfer_ready)
      else $error("transfer not taken");
   a_xfer_time: assert property (xfer_done |-> $past(xcnt_q) + 5'h01 == $past(xn_q))
      else $error("transfer duration wrong");
   a_xfer_commit: assert property (xfer_done |-> program_counter == $past(xpc_q) &&
      code_page_register == ($past(xlong_q) ? $past(xpage_q) : $past(code_page_register)))
      else $error("transfer commit wrong");
endmodule
`default_nettype wire

// ===== verif/mqscp_sram_model.sv
`timescale 1ns/100ps
`default_nettype none
module mqscp_sram_model (
   // memory bus pins
   input wire logic        clk,
   input wire logic [19:0] mem_addr_q,
   input wire logic        chip_select_0_n, chip_select_1_n, chip_select_2_n,
   input wire logic        output_enable_0_n, output_enable_1_n, write_enable_0_n, write_enable_1_n,
   // what the chips saw during the last access
   output logic [19:0]     seen_addr,
   output logic [2:0]      seen_cs, cs_len,
   output logic [1:0]      seen_oe, seen_we
);
   // strobes are active low on the chips
   wire [2:0] cs = ~{chip_select_2_n, chip_select_1_n, chip_select_0_n};
   wire [1:0] oe = ~{output_enable_1_n, output_enable_0_n};
   wire [1:0] we = ~{write_enable_1_n, write_enable_0_n};
   wire       act = |{cs, oe, we};
   logic      act_q = 1'b0;
   // gather strobes over one access; an idle bus clears the record so nothing goes stale
   always @(posedge clk) begin
      if (act) begin
         seen_addr <= mem_addr_q;
         seen_cs <= act_q ? (seen_cs | cs) : cs;
         seen_oe <= act_q ? (seen_oe | oe) : oe;
         seen_we <= act_q ? (seen_we | we) : we;
         cs_len <= (act_q ? cs_len : 3'h0) + {2'h0, |cs};
      end else begin
         seen_addr <= 20'h0; seen_cs <= 3'h0; seen_oe <= 2'h0; seen_we <= 2'h0; cs_len <= 3'h0;
      end
      act_q <= act;
   end
endmodule
`default_nettype wire

// ===== verif/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "mqscp_defines.vh"
module tb_top;
   localparam NUM_QUADS = 4;
   logic clk = 1'b0, nrst = 1'b0, mem_req = 1'b0, mem_write = 1'b0, xfer_start = 1'b0;
   logic [15:0] logical_addr = 16'h0, xfer_target_pc = 16'h0;
   logic [7:0] zone_boundary_register = 8'h0, data_segment = 8'h0, stack_segment = 8'h0;
   logic [7:0] xfer_target_page = 8'h0, exp_page = `MQSCP_PAGE_RST;
   logic [31:0] bank_control = 32'h0, r;
   logic [2:0] xfer_kind = 3'h0, seen_cs, cs_len;
   logic [1:0] seen_oe, seen_we;
   logic [19:0] seen_addr;
   wire mem_ready, mem_done_q, xfer_ready, xfer_done;
   wire chip_select_0_n, chip_select_1_n, chip_select_2_n;
   wire output_enable_0_n, output_enable_1_n, write_enable_0_n, write_enable_1_n;
   wire [15:0] program_counter;
   wire [7:0] code_page_register;
   wire [19:0] mem_addr_q;
   integer fail_count = 0, comparisons = 0, i;
   integer meas [0:7];
   always #25 clk = ~clk;
   mqscp_mem_iface #(.NUM_QUADS(NUM_QUADS)) i_mqscp_mem_iface (.clk, .nrst, .mem_req, .mem_write,
      .logical_addr, .mem_ready, .mem_done_q, .zone_boundary_register, .data_segment,
      .stack_segment, .bank_control, .xfer_start, .xfer_kind, .xfer_target_pc, .xfer_target_page,
      .xfer_ready, .xfer_done, .program_counter, .code_page_register, .mem_addr_q,
      .chip_select_0_n, .chip_select_1_n, .chip_select_2_n, .output_enable_0_n,
      .output_enable_1_n, .write_enable_0_n, .write_enable_1_n);
   mqscp_sram_model i_mqscp_sram_model (.clk, .mem_addr_q, .chip_select_0_n, .chip_select_1_n,
      .chip_select_2_n, .output_enable_0_n, .output_enable_1_n, .write_enable_0_n,
      .write_enable_1_n, .seen_addr, .seen_cs, .cs_len, .seen_oe, .seen_we);
   task compare(input logic [19:0] got, input logic [19:0] exp);
      begin
         comparisons = comparisons + 1;
         if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
         end
      end
   endtask
   // expected transfer length per kind
   function [19:0] xlen(input logic [2:0] k);
      xlen = (k == 3'h0) ? 20'd7 : (k == 3'h1) ? 20'd12 : (k == 3'h2) ? 20'd8 :
             (k == 3'h3) ? 20'd10 : (k == 3'h4) ? 20'd19 : 20'd13;
   endfunction
   // one access; the model's record is read before the idle bus clears it
   task mem_acc(input logic w, input logic [15:0] a);
      logic [7:0] seg, fld;
      logic [19:0] p;
      logic [1:0] pr;
      logic hit;
      begin
         seg = (a[15:12] >= 4'he) ? exp_page : (a[15:12] >= zone_boundary_register[7:4]) ?
               stack_segment : (a[15:12] >= zone_boundary_register[3:0]) ? data_segment : 8'h00;
         p = {4'h0, a} + {seg, 12'h000};
         fld = bank_control >> {p[19:18], 3'b000};
         p = p ^ {fld[6], fld[5], 1'b0, fld[4], 16'h0000};
         pr = fld[2] ? (fld[3] ? 2'b10 : 2'b01) : 2'b00;
         hit = (fld[1:0] != 2'h3) || fld[2];
         mem_req = 1'b1; mem_write = w; logical_addr = a;
         @(posedge clk); #5 mem_req = 1'b0;
         repeat (2) @(posedge clk);
         #5 compare(mem_done_q, 20'h1);
         compare(seen_cs, (fld[1:0] == 2'h3) ? 20'h0 : (20'h1 << fld[1:0]));
         compare(seen_oe, w ? 20'h0 : pr);
         compare(seen_we, w ? pr : 20'h0);
         compare(seen_addr, hit ? p : 20'h0);
         compare(cs_len, (fld[1:0] == 2'h3) ? 20'h0 : 20'h2);
      end
   endtask
   task xfer(input logic [2:0] k, input logic [15:0] pc, input logic [7:0] pg);
      integer n;
      begin
         xfer_start = 1'b1; xfer_kind = k; xfer_target_pc = pc; xfer_target_page = pg; n = 0;
         @(posedge clk); #5 xfer_start = 1'b0;
         while (xfer_done !== 1'b1 && n < 40) begin
            @(posedge clk); #5 n = n + 1;
         end
         meas[k] = n;
         if (k >= `MQSCP_XK_LJP) exp_page = pg;
         compare(n[19:0], xlen(k));
         compare(program_counter, pc);
         compare(code_page_register, exp_page);
      end
   endtask
   task wrap_up;
      begin
         $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
         if (fail_count == 0 && comparisons > 0) $display("No errors found");
         else $display("Errors were found");
         $finish;
      end
   endtask
   // watchdog well above the expected run of some 600 cycles
   initial begin
      #1000000 fail_count = fail_count + 1;
      wrap_up;
   end
   initial begin
      repeat (6) @(posedge clk);
      #5 compare({chip_select_2_n, chip_select_1_n, chip_select_0_n, output_enable_1_n,
         output_enable_0_n, write_enable_1_n, write_enable_0_n}, 20'h7f);
      compare(mem_addr_q, 20'h0);
      nrst = 1'b1;
      r = $urandom(32'h5ed8cf96);
      $display("test reset done");
      for (i = 0; i < 6; i = i + 1) xfer(i[2:0], 16'h1000 + i[15:0], 8'h40 + i[7:0]);
      compare(meas[4] + meas[5], 20'd32);
      compare(meas[1] + meas[2], 20'd20);
      $display("test transfer kinds done");
      for (i = 0; i < 90; i = i + 1) begin
         r = $urandom;
         zone_boundary_register = r[7:0]; data_segment = r[15:8]; stack_segment = r[23:16];
         bank_control = $urandom;
         r = $urandom;
         if (r[1:0] == 2'h0) xfer((r[4:2] > 3'h5) ? {1'b0, r[3:2]} : r[4:2], r[31:16], r[15:8]);
         else mem_acc(r[5], r[31:16]);
      end
      $display("test random traffic done");
      // second reset mid-run, then zone edges and the wrapping top of the code window
      nrst = 1'b0;
      @(posedge clk); #5 nrst = 1'b1;
      exp_page = `MQSCP_PAGE_RST;
      compare(code_page_register, 20'h0);
      bank_control = 32'h6d7a_2c41; zone_boundary_register = 8'h84;
      mem_acc(1'b1, 16'h8000);
      mem_acc(1'b0, 16'h7fff);
      mem_acc(1'b0, 16'h4000);
      mem_acc(1'b1, 16'h3fff);
      xfer(`MQSCP_XK_LJP, 16'he000, 8'hff);
      mem_acc(1'b0, 16'hffff);
      mem_acc(1'b1, 16'he000);
      $display("test corners done");
      wrap_up;
   end
endmodule
bind mqscp_mem_iface mqscp_checker #(.NUM_QUADS(NUM_QUADS)) i_mqscp_checker (.clk, .nrst,
   .mem_req, .mem_write, .mem_ready, .mem_done_q, .logical_addr, .xfer_target_pc,
   .program_counter, .zone_boundary_register, .data_segment, .stack_segment, .bank_control,
   .xfer_start, .xfer_ready, .xfer_done, .xfer_kind, .xfer_target_page, .code_page_register,
   .mem_addr_q, .chip_select_0_n, .chip_select_1_n, .chip_select_2_n, .output_enable_0_n,
   .output_enable_1_n, .write_enable_0_n, .write_enable_1_n);
`default_nettype wire
